// ===== hdl/lpc_ctrl.sv
// Purpose: power-down, idle, slow idle, cycle-clock and reset control
// Assumes: sys_clk is the processor cycle clock; requests synchronous
// Notes:   processor core handshakes via idle and handler strobes
`timescale 1ns/1ps
module lpc_ctrl
  import lpc_pkg::*;
#(
  parameter int COLD_WAIT = COLD_CYCLES,
  parameter int WARM_WAIT = WARM_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        powerdown_request_pin_n,
  input  wire logic        powerdown_force,
  input  wire logic        pd_enter,
  input  wire logic        osc_stop,
  input  wire logic        context_clear,
  input  wire logic        idle_exec,
  input  wire logic        idle_div_valid,
  input  wire logic [1:0]  idle_div_code,
  input  wire logic        unmasked_irq,
  input  wire logic        cycle_clock_out_disable,
  input  wire logic        memory_map_select,
  input  wire logic        bus_request,
  input  wire logic        boot_done,
  output logic             powerdown_ack_pin,
  output logic             pd_irq,
  output logic             core_run,
  output logic             core_tick,
  output logic             serial_clk_en,
  output logic             timer_clk_en,
  output logic             cycle_clock_output,
  output logic             osc_enable,
  output logic             resume_saved,
  output logic             restart_clean,
  output logic             boot_active,
  output logic [13:0]      fetch_addr,
  output logic             fetch_load,
  output logic [15:0]      mode_status_register,
  output logic [11:0]      irq_mask,
  output logic             stacks_empty
);
  import lpc_pkg::*;

  // ---------------------------------------------------------------
  // State and registers
  // ---------------------------------------------------------------
  lpc_state_t     state_reg, state_next;
  logic [CNT_W-1:0] wait_reg, wait_next;
  logic           req_d_reg;
  logic           ack_reg;
  logic           irq_reg;
  logic           div_reg;
  logic [1:0]     code_reg;
  logic           osc_reg;
  logic           ctx_reg;
  logic           ccout_reg;
  logic           first_reg;
  logic           fetch_reg;
  logic           clean_reg;
  logic           saved_reg;
  logic           tick;

  wire req_edge   = req_d_reg && !powerdown_request_pin_n;
  wire pd_go      = pd_enter && (!powerdown_request_pin_n || powerdown_force);
  wire req_leave  = powerdown_request_pin_n && !powerdown_force;
  wire boot_sel   = !bus_request && (memory_map_select == 1'b0);
  wire wait_done  = (wait_reg == '0);

  lpc_clk_div u_div (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .div_on     (div_reg),
    .ratio_code (code_reg),
    .tick       (tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_done ? wait_reg : wait_reg - 1'b1;
    case (state_reg)
      ST_BOOT: begin
        if (boot_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pd_go) begin
          state_next = ST_PDOWN;
        end else if (idle_exec) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Exit only on a divided tick, so slow idle may lag by up to n cycles
        if (unmasked_irq && tick) begin
          state_next = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (req_leave) begin
          state_next = ST_WAKE;
          wait_next  = osc_reg ? CNT_W'(COLD_WAIT - 1) : CNT_W'(WARM_WAIT - 1);
        end
      end
      ST_WAKE: begin
        if (wait_done) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      wait_reg  <= '0;
      req_d_reg <= 1'b1;
      ack_reg   <= 1'b0;
      irq_reg   <= 1'b0;
      div_reg   <= 1'b0;
      code_reg  <= DIV_NONE;
      osc_reg   <= 1'b0;
      ctx_reg   <= 1'b0;
      ccout_reg <= 1'b0;
      first_reg <= 1'b1;
      fetch_reg <= 1'b0;
      clean_reg <= 1'b0;
      saved_reg <= 1'b0;
    end else begin
      first_reg <= 1'b0;
      if (first_reg) begin
        state_reg <= boot_sel ? ST_BOOT : ST_RUN;
      end else begin
        state_reg <= state_next;
      end
      wait_reg  <= wait_next;
      req_d_reg <= powerdown_request_pin_n;
      irq_reg   <= req_edge;
      ack_reg   <= (state_next == ST_PDOWN) && !first_reg;
      if (state_reg == ST_RUN && idle_exec) begin
        div_reg  <= idle_div_valid;
        code_reg <= idle_div_code;
      end else if (state_next != ST_IDLE) begin
        div_reg  <= 1'b0;
      end
      if (state_reg == ST_RUN && pd_go) begin
        osc_reg <= osc_stop;
        ctx_reg <= context_clear;
      end
      ccout_reg <= cycle_clock_out_disable ? 1'b0 : (tick ? !ccout_reg : ccout_reg);
      fetch_reg <= (state_reg == ST_BOOT && boot_done) || (first_reg && !boot_sel);
      clean_reg <= (state_reg == ST_WAKE && wait_done && ctx_reg);
      saved_reg <= (state_reg == ST_WAKE && wait_done && !ctx_reg);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign powerdown_ack_pin    = ack_reg;
  assign pd_irq               = irq_reg;
  assign core_run             = (state_reg == ST_RUN) || (state_reg == ST_BOOT);
  assign core_tick            = tick;
  assign serial_clk_en        = tick;
  assign timer_clk_en         = tick;
  assign cycle_clock_output   = ccout_reg;
  assign osc_enable           = !(state_reg == ST_PDOWN && osc_reg);
  assign resume_saved         = saved_reg;
  assign restart_clean        = clean_reg;
  assign boot_active          = (state_reg == ST_BOOT);
  assign fetch_addr           = BOOT_ADDR;
  assign fetch_load           = fetch_reg;
  assign mode_status_register = first_reg ? MODE_STATUS_REGISTER_RESET : 16'h0000;
  assign irq_mask             = IMASK_RESET;
  assign stacks_empty         = first_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  pd_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_RUN && pd_go && !first_reg |=> state_reg == ST_PDOWN)
    else $error("power-down not entered");
  ack_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_PDOWN |-> powerdown_ack_pin)
    else $error("ack missing in power-down");
  ack_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_PDOWN && req_leave |=> !powerdown_ack_pin)
    else $error("ack held while leaving");
  irq_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(powerdown_request_pin_n) |=> pd_irq)
    else $error("power-down interrupt missing");
  warm_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_PDOWN && req_leave && !osc_reg |-> ##[1:201] state_reg != ST_WAKE)
    else $error("warm wake too slow");
  std_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_IDLE && !div_reg && unmasked_irq |=> state_reg == ST_RUN)
    else $error("standard idle exit late");
  boot_pick_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    first_reg && boot_sel |=> state_reg == ST_BOOT)
    else $error("boot not started");
  ccout_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cycle_clock_out_disable |=> !cycle_clock_output)
    else $error("cycle clock not disabled");
  reset_run_a: assert property (@(posedge sys_clk)
    !rst_n |=> !powerdown_ack_pin && state_reg == ST_RUN)
    else $error("reset did not end power-down");

endmodule

// ===== hdl/lpc_pkg.sv
// Purpose: constants for the low power clock and reset controller
// Assumes: sys_clk at 40 MHz is the processor cycle clock
// Notes:   input clock runs at half the processor cycle rate
package lpc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ            = 40;
  localparam int IN_CLK_PER_CYCLES  = 2;   // Processor cycles per input-clock cycle
  localparam int WARM_IN_CYCLES     = 100;
  localparam int COLD_IN_CYCLES     = 4096;
  localparam int WARM_CYCLES        = WARM_IN_CYCLES * IN_CLK_PER_CYCLES;
  localparam int COLD_CYCLES        = COLD_IN_CYCLES * IN_CLK_PER_CYCLES;
  localparam int CNT_W              = 16;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [15:0] MODE_STATUS_REGISTER_RESET  = 16'h0000;
  localparam logic [11:0] IMASK_RESET  = 12'h000;
  localparam logic [13:0] BOOT_ADDR    = 14'h0000;
  localparam logic [1:0]  DIV_NONE     = 2'h0;
  localparam int          DIV_SHIFT_BASE = 4;  // Code k selects divisor 2**(k+4)
  localparam int          DIV_CNT_W    = 7;

  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_IDLE  = 5'h02,
    ST_PDOWN = 5'h04,
    ST_WAKE  = 5'h08,
    ST_BOOT  = 5'h10
  } lpc_state_t;

endpackage

// ===== hdl/lpc_clk_div.sv
// Purpose: divided processor-cycle enable for slow idle
// Assumes: ratio code stable while enabled
// Notes:   pulse every cycle when division is off
`timescale 1ns/1ps
module lpc_clk_div
  import lpc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       div_on,
  input  wire logic [1:0] ratio_code,
  output logic            tick
);
  import lpc_pkg::*;

  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_CNT_W-1:0] cnt_next;
  logic [DIV_CNT_W-1:0] top;

  // Shift amount kept 32 bits wide so the base of four is not cut to two bits
  assign top = DIV_CNT_W'((32'h1 << (int'(ratio_code) + DIV_SHIFT_BASE)) - 1);
  assign tick = !div_on || (cnt_reg == top);
  assign cnt_next = tick ? '0 : cnt_reg + 1'b1;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  tick_spacing_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    div_on && ratio_code == 2'h0 && tick ##1 div_on && ratio_code == 2'h0 |-> !tick[*8])
    else $error("divided tick too early");

endmodule

// ===== testbench/lpc_sys_model.sv
// Purpose: system-side model driving reset and the power-down request pin
// Assumes: sys_clk runs free; this model never stops or slows it
// Notes:   power-up reset hold shortened by parameter to keep runs short
`timescale 1ns/1ps
module lpc_sys_model #(
  parameter int HOLD = 8
)
(
  input  wire logic sys_clk,
  input  wire logic pd_req,
  input  wire logic rst_req,
  output logic      rst_n,
  output logic      powerdown_request_pin_n
);
  int cnt;
  initial begin
    cnt = 0;
    rst_n = 1'b0;
    powerdown_request_pin_n = 1'b1;
  end
  // Input clock is left running through normal operation
  always @(posedge sys_clk) begin
    if (cnt < HOLD) cnt <= cnt + 1;
    rst_n <= (cnt >= HOLD - 1) && !rst_req;
    powerdown_request_pin_n <= !pd_req;
  end
endmodule

// ===== testbench/low_power_clock_reset_ctrl_tb.sv
// Purpose: self-checking bench for the power-down, idle and reset controller
// Assumes: short wake waits set by parameters, wake-time expectations from them
// Notes:   bounds allow a few cycles of registered latency
`timescale 1ns/1ps
module low_power_clock_reset_ctrl_tb;
  import lpc_pkg::*;
  localparam int CW = 16;
  localparam int WW = 4;
  logic sys_clk = 1'b0;
  logic rst_n, powerdown_request_pin_n, pd_req = 0, rst_req = 0;
  logic powerdown_force = 0, pd_enter = 0, osc_stop = 0, context_clear = 0;
  logic idle_exec = 0, idle_div_valid = 0, unmasked_irq = 0, boot_done = 0;
  logic cycle_clock_out_disable = 0, memory_map_select = 0, bus_request = 0;
  logic [1:0] idle_div_code = 2'h0;
  logic powerdown_ack_pin, pd_irq, core_run, core_tick, serial_clk_en, timer_clk_en;
  logic cycle_clock_output, osc_enable, resume_saved, restart_clean, boot_active;
  logic fetch_load, stacks_empty, v;
  logic [13:0] fetch_addr;
  logic [15:0] mode_status_register;
  logic [11:0] irq_mask;
  int miscompares = 0, tests_run = 0, cyc = 0, n;
  wire [8:0] watch = {fetch_load, restart_clean, resume_saved, ~powerdown_ack_pin, pd_irq,
                      boot_active, core_tick, powerdown_ack_pin, core_run};

  lpc_sys_model #(.HOLD(8)) u_sys (.sys_clk, .pd_req, .rst_req, .rst_n,
                                   .powerdown_request_pin_n);
  lpc_ctrl #(.COLD_WAIT(CW), .WARM_WAIT(WW)) u_dut (.sys_clk, .rst_n,
    .powerdown_request_pin_n, .powerdown_force, .pd_enter, .osc_stop, .context_clear,
    .idle_exec, .idle_div_valid, .idle_div_code, .unmasked_irq, .cycle_clock_out_disable,
    .memory_map_select, .bus_request, .boot_done, .powerdown_ack_pin, .pd_irq, .core_run,
    .core_tick, .serial_clk_en, .timer_clk_en, .cycle_clock_output, .osc_enable,
    .resume_saved, .restart_clean, .boot_active, .fetch_addr, .fetch_load,
    .mode_status_register, .irq_mask, .stacks_empty);

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task clk(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task wait_sig(input int sel);
    n = 0;
    // Look only once the launching edge has settled
    #1;
    while (watch[sel] !== 1'b1 && n < 9000) begin
      clk(1);
      n++;
    end
  endtask
  task enter_pd;
    @(posedge sys_clk) pd_enter <= 1'b1;
    @(posedge sys_clk) pd_enter <= 1'b0;
    wait_sig(1);
  endtask
  task go_idle(input logic val, input logic [1:0] code);
    @(posedge sys_clk) begin
      idle_exec <= 1'b1;
      idle_div_valid <= val;
      idle_div_code <= code;
    end
    @(posedge sys_clk) idle_exec <= 1'b0;
    clk(1);
  endtask
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task t_boot;
    while (rst_n !== 1'b1) clk(1);
    chk(stacks_empty, 16'h0001);
    wait_sig(3);
    chk(mode_status_register, 16'h0000);
    chk(irq_mask, 16'h0000);
    @(posedge sys_clk) boot_done <= 1'b1;
    @(posedge sys_clk) boot_done <= 1'b0;
    #1;
    chk(fetch_load, 16'h0001);
    chk(fetch_addr, 16'h0000);
    chk_rng(n, 1, 1);
    $display("boot test done");
  endtask
  task t_warm;
    @(posedge sys_clk) pd_req <= 1'b1;
    wait_sig(4);
    chk_rng(n, 1, 4);
    enter_pd;
    chk_rng(n, 0, 0);
    @(posedge sys_clk) pd_req <= 1'b0;
    wait_sig(5);
    chk_rng(n, 1, 4);
    wait_sig(0);
    chk_rng(n, WW - 2, WW + 4);
    wait_sig(6);
    chk_rng(n, 0, 2);
    $display("warm wake test done");
  endtask
  task t_cold;
    @(posedge sys_clk) begin
      osc_stop <= 1'b1;
      context_clear <= 1'b1;
      powerdown_force <= 1'b1;
    end
    enter_pd;
    chk_rng(n, 0, 0);
    chk(osc_enable, 16'h0000);
    @(posedge sys_clk) powerdown_force <= 1'b0;
    wait_sig(0);
    chk_rng(n, CW - 2, CW + 6);
    wait_sig(7);
    chk_rng(n, 0, 2);
    @(posedge sys_clk) {osc_stop, context_clear} <= 2'b00;
    @(posedge sys_clk) pd_enter <= 1'b1;
    @(posedge sys_clk) pd_enter <= 1'b0;
    clk(3);
    chk(powerdown_ack_pin, 16'h0000);
    $display("cold wake and refusal test done");
  endtask
  task t_reset_pd;
    @(posedge sys_clk) begin
      pd_req <= 1'b1;
      memory_map_select <= 1'b1;
    end
    enter_pd;
    @(posedge sys_clk) rst_req <= 1'b1;
    clk(3);
    chk(powerdown_ack_pin, 16'h0000);
    chk(core_run, 16'h0001);
    @(posedge sys_clk) {rst_req, pd_req} <= 2'b00;
    while (rst_n !== 1'b1) clk(1);
    chk(stacks_empty, 16'h0001);
    // No boot with map select high: first fetch comes one edge after release
    wait_sig(8);
    chk_rng(n, 1, 1);
    chk(core_run, 16'h0001);
    chk(boot_active, 16'h0000);
    $display("reset in power-down test done");
  endtask
  task t_idle;
    go_idle(1'b0, 2'h0);
    n = 0;
    repeat (8) begin
      n += int'(core_tick === 1'b1);
      clk(1);
    end
    chk_rng(n, 8, 8);
    @(posedge sys_clk) unmasked_irq <= 1'b1;
    wait_sig(0);
    chk_rng(n, 0, 2);
    @(posedge sys_clk) unmasked_irq <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      go_idle(1'b1, 2'(k));
      wait_sig(2);
      v = cycle_clock_output;
      clk(1);
      wait_sig(2);
      chk_rng(n + 1, 16 << k, 16 << k);
      chk({serial_clk_en, timer_clk_en}, 16'h0003);
      chk(cycle_clock_output, {15'h0000, ~v});
      @(posedge sys_clk) unmasked_irq <= 1'b1;
      wait_sig(0);
      chk_rng(n, 0, (16 << k) + 2);
      @(posedge sys_clk) unmasked_irq <= 1'b0;
    end
    $display("idle test done");
  endtask
  task t_cko;
    clk(2);
    v = cycle_clock_output;
    clk(1);
    chk(cycle_clock_output, {15'h0000, ~v});
    @(posedge sys_clk) cycle_clock_out_disable <= 1'b1;
    clk(3);
    v = cycle_clock_output;
    clk(1);
    chk(cycle_clock_output, {15'h0000, v});
    $display("cycle clock test done");
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end

  initial begin
    t_boot;
    t_warm;
    t_cold;
    t_reset_pd;
    t_idle;
    t_cko;
    report_and_stop;
  end
endmodule
